/* common/secure_watchdog_lockout_regs.vh */
// Constants for the security sequencer, watchdog and reset lockout logic
`ifndef SECURE_WATCHDOG_LOCKOUT_REGS_VH
`define SECURE_WATCHDOG_LOCKOUT_REGS_VH
// ==========================================
// Clock and timing
`define CLK_HZ 40000000
`define WDT_TIMEOUT_MS 1000
`define WDT_TIMEOUT_CYC ((`CLK_HZ / 1000) * `WDT_TIMEOUT_MS)
`define LOCK_WINDOW_S 3600
`define TICK_1MS_CYC (`CLK_HZ / 1000)
`define LOCK_WINDOW_MS (`LOCK_WINDOW_S * 1000)
`define RESET_PULSE_CYC 16
// ==========================================
// Lockout
`define LOCK_WARM_BOOTS 4
// ==========================================
// Sequence operation codes
`define OP_NONE 2'h0
`define OP_WDT 2'h1
`define OP_LOCK_CLR 2'h2
`define OP_OUT_LOAD 2'h3
// ==========================================
// Special address sequences, three words each
`define SEQ_LEN 3
`define SEQ_WDT_A0 32'h0000a5a0
`define SEQ_WDT_A1 32'h00005a50
`define SEQ_WDT_A2 32'h0000c3c0
`define SEQ_CLR_A0 32'h0000a5a4
`define SEQ_CLR_A1 32'h00005a54
`define SEQ_CLR_A2 32'h0000c3c4
`define SEQ_OUT_A0 32'h0000a5a8
`define SEQ_OUT_A1 32'h00005a58
`define SEQ_OUT_A2 32'h0000c3c8
`endif

/* core/sequence_decoder.v */
// Security address sequence decoder producing one-cycle operation strobes
`include "secure_watchdog_lockout_regs.vh"
module sequence_decoder #(
   parameter AW = 32
) (
   input wire i_core_clk,
   input wire i_resetn,
   input wire i_addr_valid,
   input wire [AW-1:0] i_addr,
   output reg [1:0] o_op
);
   // ==========================================
   // Step match
   localparam [1:0] ST_IDLE = 2'h0;
   localparam [1:0] ST_ONE = 2'h1;
   localparam [1:0] ST_TWO = 2'h2;

   reg [1:0] state;
   reg [1:0] seq;
   reg [1:0] next_state;
   reg [1:0] next_seq;
   reg [1:0] next_op;

   function [1:0] first_of;
      input [AW-1:0] a;
      begin
         if (a == `SEQ_WDT_A0)
            first_of = `OP_WDT;
         else if (a == `SEQ_CLR_A0)
            first_of = `OP_LOCK_CLR;
         else if (a == `SEQ_OUT_A0)
            first_of = `OP_OUT_LOAD;
         else
            first_of = `OP_NONE;
      end
   endfunction

   function [AW-1:0] word_of;
      input [1:0] s;
      input [1:0] idx;
      begin
         case ({s, idx})
            4'h5: word_of = `SEQ_WDT_A1;
            4'h6: word_of = `SEQ_WDT_A2;
            4'h9: word_of = `SEQ_CLR_A1;
            4'ha: word_of = `SEQ_CLR_A2;
            4'hd: word_of = `SEQ_OUT_A1;
            4'he: word_of = `SEQ_OUT_A2;
            default: word_of = {AW{1'b1}};
         endcase
      end
   endfunction

   always @* begin
      next_state = state;
      next_seq = seq;
      next_op = `OP_NONE;
      if (i_addr_valid) begin
         case (state)
            ST_IDLE: begin
               next_seq = first_of(i_addr);
               next_state = (next_seq == `OP_NONE) ? ST_IDLE : ST_ONE;
            end
            ST_ONE: begin
               if (i_addr == word_of(seq, 2'h1)) begin
                  next_state = ST_TWO;
               end else begin
                  // A breaking address may start a fresh sequence
                  next_seq = first_of(i_addr);
                  next_state = (next_seq == `OP_NONE) ? ST_IDLE : ST_ONE;
               end
            end
            ST_TWO: begin
               if (i_addr == word_of(seq, 2'h2)) begin
                  next_op = seq;
                  next_state = ST_IDLE;
                  next_seq = `OP_NONE;
               end else begin
                  next_seq = first_of(i_addr);
                  next_state = (next_seq == `OP_NONE) ? ST_IDLE : ST_ONE;
               end
            end
            default: begin
               next_state = ST_IDLE;
               next_seq = `OP_NONE;
            end
         endcase
      end
   end

   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state <= ST_IDLE;
         seq <= `OP_NONE;
         o_op <= `OP_NONE;
      end else begin
         state <= next_state;
         seq <= next_seq;
         o_op <= next_op;
      end
   end
endmodule // sequence_decoder

/* core/secure_watchdog_lockout.v */
// Supervisor: sequence decoder, watchdog, reset lockout, supply-dip interrupt
// ==========================================
`include "secure_watchdog_lockout_regs.vh"
module secure_watchdog_lockout #(
   parameter AW = 32,
   parameter OUT_W = 6,
   parameter WDT_CYC = `WDT_TIMEOUT_CYC,
   parameter TICK_CYC = `TICK_1MS_CYC,
   parameter WINDOW_MS = `LOCK_WINDOW_MS,
   parameter PULSE_CYC = `RESET_PULSE_CYC
) (
   input wire i_core_clk,
   input wire i_resetn,
   input wire i_addr_valid,
   input wire [AW-1:0] i_addr,
   input wire [OUT_W-1:0] i_out_pending,
   input wire i_supply_dip,
   output reg [OUT_W-1:0] o_relay_out,
   output reg o_cpu_resetn,
   output reg o_nmi,
   output reg o_locked,
   output reg [2:0] o_boot_count
);
   wire [1:0] op;
   reg [31:0] wdt_cnt;
   reg [31:0] tick_cnt;
   reg [31:0] ms_cnt;
   reg [7:0] pulse_cnt;
   reg in_reset;

   sequence_decoder #(
      .AW(AW)
   ) u_decoder (
      .i_core_clk(i_core_clk),
      .i_resetn(i_resetn),
      .i_addr_valid(i_addr_valid),
      .i_addr(i_addr),
      .o_op(op)
   );

   wire kick = (op == `OP_WDT) && !in_reset && !o_locked;
   wire clr = (op == `OP_LOCK_CLR) && !in_reset && !o_locked;
   wire load = (op == `OP_OUT_LOAD) && !in_reset && !o_locked;
   wire timeout = !in_reset && !o_locked && (wdt_cnt >= WDT_CYC - 1);
   wire tick = (tick_cnt >= TICK_CYC - 1);
   // Reset that would be the fourth warm boot becomes the lockout instead
   wire lock_now = timeout && (o_boot_count == `LOCK_WARM_BOOTS - 1);

   // ==========================================
   // Output stage: only its own sequence moves it
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn)
         o_relay_out <= {OUT_W{1'b0}};
      else if (load)
         o_relay_out <= i_out_pending;
   end

   // ==========================================
   // Watchdog and processor reset pulse
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wdt_cnt <= 32'h0;
         pulse_cnt <= 8'h0;
         in_reset <= 1'b0;
         o_cpu_resetn <= 1'b0;
      end else begin
         o_cpu_resetn <= !(in_reset || o_locked || timeout || lock_now);
         if (kick || in_reset)
            wdt_cnt <= 32'h0;
         else if (!o_locked)
            wdt_cnt <= wdt_cnt + 32'h1;
         if (timeout) begin
            in_reset <= 1'b1;
            pulse_cnt <= 8'h0;
         end else if (in_reset) begin
            pulse_cnt <= pulse_cnt + 8'h1;
            if (pulse_cnt >= PULSE_CYC - 1)
               in_reset <= 1'b0;
         end
      end
   end

   // ==========================================
   // Lockout counter with hourly window
   // Window restarts at each clear; clear or expiry zeroes the count except in a cycle that also times out
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tick_cnt <= 32'h0;
         ms_cnt <= 32'h0;
         o_boot_count <= 3'h0;
         o_locked <= 1'b0;
      end else begin
         tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
         if (clr || (tick && ms_cnt >= WINDOW_MS - 1)) begin
            ms_cnt <= 32'h0;
            if (!timeout)
               o_boot_count <= 3'h0;
         end else if (tick)
            ms_cnt <= ms_cnt + 32'h1;
         if (timeout && !lock_now)
            o_boot_count <= o_boot_count + 3'h1;
         if (lock_now)
            o_locked <= 1'b1;
      end
   end

   // ==========================================
   // Supply dip interrupt request, held while dip lasts
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn)
         o_nmi <= 1'b0;
      else
         o_nmi <= i_supply_dip;
   end
endmodule // secure_watchdog_lockout

/* test/secure_watchdog_lockout_props.sv */
// Assertion checker for the supervisor block ports
`include "secure_watchdog_lockout_regs.vh"
module secure_watchdog_lockout_props #(
   parameter WDT_CYC = 50
) (
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_addr_valid,
   input wire logic [31:0] i_addr,
   input wire logic [5:0] i_out_pending,
   input wire logic i_supply_dip,
   input wire logic [5:0] o_relay_out,
   input wire logic o_cpu_resetn,
   input wire logic o_nmi,
   input wire logic o_locked,
   input wire logic [2:0] o_boot_count
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_resetn);
   logic [31:0] a1, a2;
   int idle;
   wire v = i_addr_valid;
   wire kick = v && i_addr == `SEQ_WDT_A2 && a2 == `SEQ_WDT_A1 && a1 == `SEQ_WDT_A0;
   wire clr = v && i_addr == `SEQ_CLR_A2 && a2 == `SEQ_CLR_A1 && a1 == `SEQ_CLR_A0;
   wire ld = v && i_addr == `SEQ_OUT_A2 && a2 == `SEQ_OUT_A1 && a1 == `SEQ_OUT_A0;
   always @(posedge i_core_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         a1 <= 32'h0;
         a2 <= 32'h0;
         idle <= 0;
      end else begin
         if (v) begin
            a1 <= a2;
            a2 <= i_addr;
         end
         idle <= (kick || !o_cpu_resetn) ? 0 : idle + 1;
      end
   end
   sequence s_pulse; !o_cpu_resetn[*5] ##1 (o_cpu_resetn || o_locked); endsequence
   sequence s_load; ld && o_cpu_resetn ##3 o_cpu_resetn; endsequence
   sequence s_clr; clr && o_cpu_resetn ##3 o_cpu_resetn; endsequence
   property p_nmi_on; $rose(i_supply_dip) |=> o_nmi; endproperty
   property p_nmi_off; $fell(i_supply_dip) |=> !o_nmi; endproperty
   property p_lock_hold; o_locked |=> o_locked && !o_cpu_resetn; endproperty
   property p_lock_cnt; $rose(o_locked) |-> $past(o_boot_count) == 3'h3; endproperty
   property p_pulse; $fell(o_cpu_resetn) |-> s_pulse; endproperty
   property p_wdt_bound; idle < WDT_CYC + 4; endproperty
   property p_boot_inc; $fell(o_cpu_resetn) |-> o_boot_count != $past(o_boot_count, 3) || o_locked; endproperty
   property p_load; s_load |-> o_relay_out == $past(i_out_pending); endproperty
   property p_only_load; $changed(o_relay_out) |-> $past(ld, 2) || !o_cpu_resetn; endproperty
   property p_clr; s_clr |-> o_boot_count == 3'h0; endproperty
   a_nmi_on: assert property (p_nmi_on) else $error("nmi missed");
   a_nmi_off: assert property (p_nmi_off) else $error("nmi stuck");
   a_lock_hold: assert property (p_lock_hold) else $error("lock left");
   a_lock_cnt: assert property (p_lock_cnt) else $error("early lock");
   a_pulse: assert property (p_pulse) else $error("pulse length");
   a_wdt_bound: assert property (p_wdt_bound) else $error("no timeout");
   a_boot_inc: assert property (p_boot_inc) else $error("boot count");
   a_load: assert property (p_load) else $error("load value");
   a_only_load: assert property (p_only_load) else $error("stray load");
   a_clr: assert property (p_clr) else $error("clear");
endmodule // secure_watchdog_lockout_props
bind secure_watchdog_lockout secure_watchdog_lockout_props #(.WDT_CYC(WDT_CYC)) props_inst (.*);

/* test/host_cpu_model.sv */
// Host processor model issuing special address sequences
`include "secure_watchdog_lockout_regs.vh"
module host_cpu_model (
   input wire logic i_core_clk,
   input wire logic i_go,
   input wire logic [1:0] i_op,
   input wire logic i_break,
   input wire logic i_cpu_resetn,
   output logic o_addr_valid = 1'b0,
   output logic [31:0] o_addr = 32'h0
);
   logic [1:0] step = 2'h0;
   logic [2:0] resets = 3'h0;
   logic [31:0] base;
   always_comb begin
      case (step)
         2'h0: base = `SEQ_WDT_A0;
         2'h1: base = `SEQ_WDT_A1;
         default: base = `SEQ_WDT_A2;
      endcase
   end
   always @(posedge i_core_clk) begin
      if (i_go || step != 2'h0) begin
         o_addr_valid <= 1'b1;
         o_addr <= base + {28'h0, i_op - 2'h1, 2'h0};
         if (i_break && step == 2'h2) o_addr <= 32'h00001234;
         step <= (step == 2'h2) ? 2'h0 : step + 2'h1;
      end else begin
         o_addr_valid <= 1'b0;
         o_addr <= ~o_addr; // Idle bus alternates between the last address and its inverse
      end
   end
   always @(negedge i_cpu_resetn) resets <= resets + 3'h1;
endmodule // host_cpu_model

/* test/secure_watchdog_lockout_bench.sv */
// Self-checking bench for the supervisor block
module secure_watchdog_lockout_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 0, rstn = 0, go = 0, brk = 0, dip = 0;
   logic [1:0] op = 2'h1;
   logic [5:0] pend = 6'h0;
   wire v, cr, nmi, lk;
   wire [31:0] a;
   wire [5:0] rel;
   wire [2:0] bc;
   int error_cnt = 0, n_compared = 0, cyc = 0;
   host_cpu_model host_cpu_model_inst (.i_core_clk(clk), .i_go(go), .i_op(op), .i_break(brk),
      .i_cpu_resetn(cr), .o_addr_valid(v), .o_addr(a));
   secure_watchdog_lockout #(.WDT_CYC(50), .TICK_CYC(2), .WINDOW_MS(400), .PULSE_CYC(4))
      secure_watchdog_lockout_inst (.i_core_clk(clk), .i_resetn(rstn), .i_addr_valid(v),
      .i_addr(a), .i_out_pending(pend), .i_supply_dip(dip), .o_relay_out(rel),
      .o_cpu_resetn(cr), .o_nmi(nmi), .o_locked(lk), .o_boot_count(bc));
   initial forever #12.5 clk = ~clk;
   task summarize;
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         error_cnt++;
         summarize();
      end
   end
   task chk(input string n, input logic [5:0] e, input logic [5:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s exp %h got %h", n, e, g);
      end
   endtask
   task send(input logic [1:0] o, input logic b, input logic [5:0] p);
      @(posedge clk) begin
         op <= o;
         brk <= b;
         pend <= p;
         go <= 1'b1;
      end
      @(posedge clk) go <= 1'b0;
      repeat (7) @(posedge clk);
      #1;
   endtask
   task t_load;
      send(2'h3, 1'b0, 6'h2a);
      chk("relay", 6'h2a, rel);
      send(2'h1, 1'b0, 6'h15);
      send(2'h2, 1'b0, 6'h15);
      chk("relay", 6'h2a, rel);
      send(2'h1, 1'b0, 6'h15);
      send(2'h3, 1'b1, 6'h15);
      chk("relay", 6'h2a, rel);
      send(2'h3, 1'b0, 6'h15);
      chk("relay", 6'h15, rel);
      $display("t_load done");
   endtask
   task t_nmi;
      @(posedge clk) dip <= 1'b1;
      repeat (2) @(posedge clk);
      #1 chk("nmi", 6'h1, nmi);
      @(posedge clk) dip <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk("nmi", 6'h0, nmi);
      $display("t_nmi done");
   endtask
   task t_wdt;
      repeat (8) send(2'h1, 1'b0, 6'h15);
      chk("cpu_resetn", 6'h1, cr);
      chk("boot", 6'h0, bc);
      repeat (70) @(posedge clk);
      #1 chk("boot", 6'h1, bc);
      send(2'h2, 1'b0, 6'h15);
      chk("boot", 6'h0, bc);
      repeat (360) @(posedge clk);
      #1 chk("locked", 6'h1, lk);
      chk("cpu_resetn", 6'h0, cr);
      $display("t_wdt done");
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      t_load();
      t_nmi();
      t_wdt();
      summarize();
   end
endmodule // secure_watchdog_lockout_bench
